// *** src/pegp_pkg.sv ***
// Package with register map, reset values and carrier types of the port E/F GPIO
package pegp_pkg;

  // ********************************************************************
  // Register map, byte addresses of aligned 32-bit words
  // ********************************************************************
  localparam logic [3:0] PE_DIR_PIN_OFFSET = 4'h0; // Direction write, pin read
  localparam logic [3:0] PE_LATCH_OFFSET = 4'h4;
  localparam logic [3:0] PF_DIR_PIN_OFFSET = 4'h8; // Direction write, pin read
  localparam logic [3:0] PF_LATCH_OFFSET = 4'hC;

  // ********************************************************************
  // Widths and reset values
  // ********************************************************************
  localparam int PE_WIDTH = 8;
  localparam int PF_WIDTH = 3;
  localparam logic [7:0] PE_DIR_RESET = 8'h00;
  localparam logic [7:0] PE_LATCH_RESET = 8'h00;
  localparam logic [2:0] PF_DIR_RESET = 3'h0;
  localparam logic [2:0] PF_LATCH_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  // Captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] offset;
  } pegp_addr_phase_type;

  // Pad drive of one port: data and active-low output enable
  typedef struct packed {
    logic [7:0] dataOut;
    logic [7:0] pwm_channel_output_enable;
  } pegp_pad_e_type;

  typedef struct packed {
    logic [2:0] dataOut;
    logic [2:0] pwm_channel_output_enable;
  } pegp_pad_f_type;

endpackage

// *** src/pegp_port_ef.sv ***
// Port E and port F GPIO with LPC and PWM pin multiplexing, AHB-Lite slave
`timescale 1ns/1ps
module pegp_port_ef (
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Port E pads
  input wire logic [7:0] portEIn,
  output logic [7:0] portEOut,
  output logic [7:0] portEOeN,
  // Port F pads
  input wire logic [2:0] portFIn,
  output logic [2:0] portFOut,
  output logic [2:0] portFOeN,
  // Host interface channel enables, same clock
  input wire logic hostChannelOneEnable,
  input wire logic hostChannelTwoEnable,
  input wire logic hostChannelThreeEnable,
  // Host interface side of the shared pins
  input wire logic serialIrqOut,
  input wire logic serialIrqOeN,
  input wire logic [3:0] lpcAddrDataOut,
  input wire logic [3:0] lpcAddrDataOeN,
  output logic serialIrqIn,
  output logic lpcClock,
  output logic lpcResetN,
  output logic lpcFrameN,
  output logic [3:0] lpcAddrDataIn,
  // PWM side of port F
  input wire logic pwmPinSelect,
  input wire logic [2:0] pwmChannelOutputEnable,
  input wire logic [2:0] altPwmOut
);

  // ********************************************************************
  // Reset release
  // ********************************************************************
  logic [1:0] rstSync_reg;
  logic rstnSys;

  // Assert at once, release only after two clean edges
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rstSync_reg <= 2'h0;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rstnSys = rstSync_reg[1];

  // ********************************************************************
  // Pin input synchronisers
  // ********************************************************************
  logic [7:0] peMeta_reg;
  logic [7:0] peLevel_reg;
  logic [2:0] pfMeta_reg;
  logic [2:0] pfLevel_reg;

  // Pins are asynchronous; only the second stage is ever read
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      peMeta_reg <= 8'h00;
      peLevel_reg <= 8'h00;
      pfMeta_reg <= 3'h0;
      pfLevel_reg <= 3'h0;
    end
    else
    begin
      peMeta_reg <= portEIn;
      peLevel_reg <= peMeta_reg;
      pfMeta_reg <= portFIn;
      pfLevel_reg <= pfMeta_reg;
    end
  end

  // ********************************************************************
  // AHB-Lite address phase capture
  // ********************************************************************
  pegp_pkg::pegp_addr_phase_type addrPhase_reg;
  pegp_pkg::pegp_addr_phase_type addrPhase_next;
  logic acceptPhase;
  logic mapped;

  // Whole-word single transfers only; hsize is not decoded
  assign acceptPhase = hsel && hready && (htrans == pegp_pkg::HTRANS_NONSEQ);
  assign mapped = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);

  always_comb
  begin
    addrPhase_next.valid = acceptPhase && mapped;
    addrPhase_next.write = hwrite;
    addrPhase_next.offset = haddr[3:0];
  end

  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
      addrPhase_reg <= '0;
    else
      addrPhase_reg <= addrPhase_next;
  end

  // Zero wait states and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ********************************************************************
  // Register writes in the data phase
  // ********************************************************************
  logic [7:0] peDir_reg;
  logic [7:0] peLatch_reg;
  logic [2:0] pfDir_reg;
  logic [2:0] pfLatch_reg;
  logic wrPhase;

  assign wrPhase = addrPhase_reg.valid && addrPhase_reg.write;

  // Port E direction, written through the pin-level address
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
      peDir_reg <= pegp_pkg::PE_DIR_RESET;
    else if (wrPhase &&
             addrPhase_reg.offset == pegp_pkg::PE_DIR_PIN_OFFSET)
      peDir_reg <= hwdata[7:0];
  end

  // Port E output latch
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
      peLatch_reg <= pegp_pkg::PE_LATCH_RESET;
    else if (wrPhase &&
             addrPhase_reg.offset == pegp_pkg::PE_LATCH_OFFSET)
      peLatch_reg <= hwdata[7:0];
  end

  // Port F direction, written through the pin-level address
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
      pfDir_reg <= pegp_pkg::PF_DIR_RESET;
    else if (wrPhase &&
             addrPhase_reg.offset == pegp_pkg::PF_DIR_PIN_OFFSET)
      pfDir_reg <= hwdata[2:0];
  end

  // Port F output latch
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
      pfLatch_reg <= pegp_pkg::PF_LATCH_RESET;
    else if (wrPhase &&
             addrPhase_reg.offset == pegp_pkg::PF_LATCH_OFFSET)
      pfLatch_reg <= hwdata[2:0];
  end

  // ********************************************************************
  // Read data, registered at the address phase
  // ********************************************************************
  logic [31:0] rdData_next;

  // Direction bits are write-only: their address returns pin levels
  always_comb
  begin
    rdData_next = 32'h00000000;
    if (acceptPhase && mapped && !hwrite)
    begin
      unique case (haddr[3:0])
        pegp_pkg::PE_DIR_PIN_OFFSET: rdData_next[7:0] = peLevel_reg;
        pegp_pkg::PE_LATCH_OFFSET: rdData_next[7:0] = peLatch_reg;
        pegp_pkg::PF_DIR_PIN_OFFSET: rdData_next[2:0] = pfLevel_reg;
        pegp_pkg::PF_LATCH_OFFSET: rdData_next[2:0] = pfLatch_reg;
        default: rdData_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
      hrdata <= 32'h00000000;
    else
      hrdata <= rdData_next;
  end

  // ********************************************************************
  // Port E pin multiplexing
  // ********************************************************************
  logic lpcEnabled;
  pegp_pkg::pegp_pad_e_type padE;

  // Any one channel enable claims all eight pins
  assign lpcEnabled = hostChannelOneEnable || hostChannelTwoEnable ||
                      hostChannelThreeEnable;

  always_comb
  begin
    if (lpcEnabled)
    begin
      padE.dataOut = {serialIrqOut, 3'h0, lpcAddrDataOut};
      padE.pwm_channel_output_enable = {serialIrqOeN, 3'h7, lpcAddrDataOeN};
    end
    else
    begin
      padE.dataOut = peLatch_reg;
      padE.pwm_channel_output_enable = ~peDir_reg;
    end
  end

  assign portEOut = padE.dataOut;
  assign portEOeN = padE.pwm_channel_output_enable;

  // Shared pins reach the host interface as plain routing; the LPC clock
  // must not pass a resampler, and the host logic syncs its own inputs
  assign serialIrqIn = lpcEnabled ? portEIn[7] : 1'b1;
  assign lpcClock = lpcEnabled ? portEIn[6] : 1'b0;
  assign lpcResetN = lpcEnabled ? portEIn[5] : 1'b0;
  assign lpcFrameN = lpcEnabled ? portEIn[4] : 1'b1;
  assign lpcAddrDataIn = lpcEnabled ? portEIn[3:0] : 4'hF;

  // ********************************************************************
  // Port F pin multiplexing, one slice per pin
  // ********************************************************************
  pegp_pkg::pegp_pad_f_type padF;

  generate
    for (genvar n = 0; n < pegp_pkg::PF_WIDTH; n++)
    begin : gPinF
      logic pwmOwns;
      assign pwmOwns = pwmPinSelect && pwmChannelOutputEnable[n];
      // PWM drives the pin outright; otherwise direction decides
      assign padF.dataOut[n] = pwmOwns ? altPwmOut[n] : pfLatch_reg[n];
      assign padF.pwm_channel_output_enable[n] = pwmOwns ? 1'b0 : ~pfDir_reg[n];
    end
  endgenerate

  assign portFOut = padF.dataOut;
  assign portFOeN = padF.pwm_channel_output_enable;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (!rstnSys);

  chk_pe_read_pins: assert property (
    (acceptPhase && mapped && !hwrite &&
     haddr[3:0] == pegp_pkg::PE_DIR_PIN_OFFSET)
    |=> hrdata == {24'h000000, $past(peLevel_reg)})
    else $error("Port E read does not return pin levels");

  chk_pe_dir_write: assert property (
    (wrPhase && addrPhase_reg.offset == pegp_pkg::PE_DIR_PIN_OFFSET)
    |=> peDir_reg == $past(hwdata[7:0]))
    else $error("Port E direction not written via pin address");

  chk_pe_gpio_dir: assert property (
    !lpcEnabled |-> (portEOeN == ~peDir_reg) &&
                    ((portEOut & peDir_reg) == (peLatch_reg & peDir_reg)))
    else $error("Port E general pins do not follow direction");

  chk_pe_lpc_pins: assert property (
    lpcEnabled |-> (portEOeN[6:4] == 3'h7) &&
                   (portEOeN[7] == serialIrqOeN) &&
                   (portEOut[3:0] == lpcAddrDataOut) &&
                   (portEOeN[3:0] == lpcAddrDataOeN))
    else $error("Port E pins not handed to host interface");

  chk_pf_dir_write: assert property (
    (wrPhase && addrPhase_reg.offset == pegp_pkg::PF_DIR_PIN_OFFSET)
    |=> pfDir_reg == $past(hwdata[2:0]))
    else $error("Port F direction not written via pin address");

  chk_pf_read_pins: assert property (
    (acceptPhase && mapped && !hwrite &&
     haddr[3:0] == pegp_pkg::PF_DIR_PIN_OFFSET)
    |=> hrdata == {29'h00000000, $past(pfLevel_reg)})
    else $error("Port F read does not return pin levels");

  chk_pf_pwm_route: assert property (
    pwmPinSelect |-> ((portFOut & pwmChannelOutputEnable) ==
                      (altPwmOut & pwmChannelOutputEnable)) &&
                     ((portFOeN & pwmChannelOutputEnable) == 3'h0))
    else $error("PWM outputs not routed to port F");

  chk_latch_to_pin: assert property (
    (wrPhase && addrPhase_reg.offset == pegp_pkg::PF_LATCH_OFFSET &&
     !pwmPinSelect) ##1 !pwmPinSelect
    |-> (portFOut == $past(hwdata[2:0])))
    else $error("Port F latch write not on pins next cycle");

  chk_reset_dirs: assert property (
    $rose(rstSync_reg[1]) |-> (pfDir_reg == 3'h0) && (peDir_reg == 8'h00) &&
                              (pfLatch_reg == 3'h0))
    else $error("Direction or latch not cleared by reset");

  // Pin levels trail the pads by two edges; the reset-cleared stages wait
  chk_pin_levels: assert property (
    $past(rstnSys, 2) |-> (peLevel_reg == $past(portEIn, 2)) &&
                          (pfLevel_reg == $past(portFIn, 2)))
    else $error("Pin levels do not follow the pads");

  chk_host_inputs: assert property (
    lpcEnabled |-> {serialIrqIn, lpcClock, lpcResetN, lpcFrameN,
                    lpcAddrDataIn} == portEIn)
    else $error("Shared pins not routed to host interface");

  chk_host_idle: assert property (
    !lpcEnabled |-> {serialIrqIn, lpcClock, lpcResetN, lpcFrameN,
                     lpcAddrDataIn} == 8'h9F)
    else $error("Host interface inputs not parked while disabled");

  chk_serirq_drive: assert property (
    lpcEnabled |-> (portEOut[7] == serialIrqOut) &&
                   (portEOeN[7] == serialIrqOeN))
    else $error("Pin E7 not driven by serial interrupt");

  chk_lad_drive: assert property (
    lpcEnabled |-> (portEOut[3:0] == lpcAddrDataOut) &&
                   (portEOeN[3:0] == lpcAddrDataOeN))
    else $error("Pins E3 to E0 not driven by address/data");

  chk_pf_latch_write: assert property (
    (wrPhase && addrPhase_reg.offset == pegp_pkg::PF_LATCH_OFFSET)
    |=> pfLatch_reg == $past(hwdata[2:0]))
    else $error("Port F latch not written");

  // Pins held by the PWM are masked out of the general-purpose check
  logic [2:0] pfOwned;
  assign pfOwned = {3{pwmPinSelect}} & pwmChannelOutputEnable;

  chk_pf_gpio_dir: assert property (
    ((portFOeN | pfOwned) == (~pfDir_reg | pfOwned)) &&
    ((portFOut | pfOwned) == (pfLatch_reg | pfOwned)))
    else $error("Port F general pins do not follow direction");

  cov_lpc_take: cover property ($rose(lpcEnabled));
  cov_pwm_route: cover property (pwmPinSelect && |pwmChannelOutputEnable);
  cov_pf_write: cover property (
    wrPhase && addrPhase_reg.offset == pegp_pkg::PF_LATCH_OFFSET);
  cov_pe_read: cover property (
    acceptPhase && !hwrite && haddr[3:0] == pegp_pkg::PE_DIR_PIN_OFFSET);

endmodule

// *** bench/pegp_board_model.sv ***
// Board model that drives the pins the block releases
`timescale 1ns/1ps
module pegp_board_model (
  input wire logic [7:0] eOut,
  input wire logic [7:0] eOeN,
  input wire logic [7:0] eExt,
  input wire logic [2:0] fOut,
  input wire logic [2:0] fOeN,
  input wire logic [2:0] fExt,
  output logic [7:0] eWire,
  output logic [2:0] fWire
);
  // Board drives a pin only where the block lets go, so no contention
  assign eWire = (eOut & ~eOeN) | (eExt & eOeN);
  assign fWire = (fOut & ~fOeN) | (fExt & fOeN);
endmodule

// *** bench/tb_top.sv ***
// Self-checking testbench for the port E/F GPIO block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp;
  logic [7:0] portEIn, portEOut, portEOeN, eExt = 8'h3C;
  logic [2:0] portFIn, portFOut, portFOeN, fExt = 3'h7;
  logic [2:0] lpcEn = 3'h0, pwmEn = 3'h0, altPwm = 3'h5, own, dirF;
  logic sIrqOut = 1'b0, sIrqOeN = 1'b1, pwmSel = 1'b0;
  logic [3:0] ladOut = 4'h0, ladOeN = 4'hF, lpcAddrDataIn;
  logic serialIrqIn, lpcClock, lpcResetN, lpcFrameN;
  int err_count = 0, n_tests = 0;

  // Free-running system clock
  always #50 clk_sys = ~clk_sys;

  // Block under test; hready follows the single slave
  pegp_port_ef i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .portEIn(portEIn), .portEOut(portEOut),
    .portEOeN(portEOeN), .portFIn(portFIn), .portFOut(portFOut),
    .portFOeN(portFOeN), .hostChannelOneEnable(lpcEn[0]),
    .hostChannelTwoEnable(lpcEn[1]), .hostChannelThreeEnable(lpcEn[2]),
    .serialIrqOut(sIrqOut), .serialIrqOeN(sIrqOeN),
    .lpcAddrDataOut(ladOut), .lpcAddrDataOeN(ladOeN),
    .serialIrqIn(serialIrqIn), .lpcClock(lpcClock),
    .lpcResetN(lpcResetN), .lpcFrameN(lpcFrameN),
    .lpcAddrDataIn(lpcAddrDataIn), .pwmPinSelect(pwmSel),
    .pwmChannelOutputEnable(pwmEn), .altPwmOut(altPwm)
  );

  // Pin wires resolved from both parties
  pegp_board_model i_board (
    .eOut(portEOut), .eOeN(portEOeN), .eExt(eExt), .fOut(portFOut),
    .fOeN(portFOeN), .fExt(fExt), .eWire(portEIn), .fWire(portFIn)
  );

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic final_report;
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chkRd(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t read %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkPad(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t pad %h expected %h", $time, g, e);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic waitRdy;
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        err_count++;
        final_report;
      end
      @(posedge clk_sys);
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic busOp(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= pegp_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    waitRdy;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    waitRdy;
    rd = hrdata;
    #1;
  endtask

  // Pin reads pass a two-flop synchroniser first
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    settle;
    chkPad(portEOeN, 8'hFF);
    chkPad({5'h0, portFOeN}, 8'h07);
    chkPad({serialIrqIn, lpcClock, lpcResetN, lpcFrameN,
            lpcAddrDataIn}, 8'h9F);
    busOp(1'b0, 32'hC, 32'h0);
    chkRd(rd, 32'h0);
    busOp(1'b0, 32'h0, 32'h0);
    chkRd(rd, 32'h3C);
    busOp(1'b0, 32'h8, 32'h0);
    chkRd(rd, 32'h7);
    $display("test reset done");
    // Upper pins input from board, lower pins output the latch
    busOp(1'b1, 32'h4, 32'hA5);
    busOp(1'b1, 32'h0, 32'h0F);
    chkPad(portEOeN, 8'hF0);
    chkPad(portEOut & ~portEOeN, 8'h05);
    settle;
    busOp(1'b0, 32'h0, 32'h0);
    chkRd(rd, 32'h35);
    busOp(1'b1, 32'h0, 32'hFF);
    chkPad(portEOut & ~portEOeN, 8'hA5);
    $display("test port E done");
    // Any one channel enable hands the pins over
    eExt <= 8'hB6;
    for (int i = 0; i < 3; i++)
    begin
      lpcEn <= 3'h1 << i;
      settle;
      chkPad(portEOeN, 8'hFF);
      chkPad({serialIrqIn, lpcClock, lpcResetN, lpcFrameN,
              lpcAddrDataIn}, 8'hB6);
    end
    sIrqOeN <= 1'b0;
    sIrqOut <= 1'b1;
    ladOeN <= 4'h0;
    ladOut <= 4'h9;
    settle;
    chkPad(portEOeN, 8'h70);
    chkPad(portEOut & 8'h8F, 8'h89);
    lpcEn <= 3'h0;
    settle;
    chkPad(portEOeN, 8'h00);
    chkPad({serialIrqIn, lpcClock, lpcResetN, lpcFrameN,
            lpcAddrDataIn}, 8'h9F);
    $display("test host pins done");
    // Port F direction through the pin-level address
    busOp(1'b1, 32'h8, 32'h5);
    busOp(1'b1, 32'hC, 32'h6);
    chkPad({5'h0, portFOeN}, 8'h02);
    chkPad({5'h0, portFOut & ~portFOeN}, 8'h04);
    settle;
    busOp(1'b0, 32'h8, 32'h0);
    chkRd(rd, 32'h6);
    busOp(1'b1, 32'hC, 32'hFF);
    busOp(1'b0, 32'hC, 32'h0);
    chkRd(rd, 32'h7);
    $display("test port F done");
    // Every pin select and enable combination
    dirF = 3'h5;
    for (int s = 0; s < 2; s++)
      for (int e = 0; e < 8; e++)
      begin
        pwmSel <= s[0];
        pwmEn <= e[2:0];
        settle;
        own = {3{s[0]}} & e[2:0];
        chkPad({5'h0, portFOeN}, {5'h0, ~own & ~dirF});
        chkPad({5'h0, portFOut & ~portFOeN},
               {5'h0, (own & altPwm) | (~own & dirF)});
      end
    $display("test pwm done");
    // Unmapped word: write ignored, read zero, OKAY
    busOp(1'b1, 32'h10, 32'h0);
    busOp(1'b0, 32'h10, 32'h0);
    chkRd(rd, 32'h0);
    chkPad({7'h0, hresp}, 8'h00);
    busOp(1'b0, 32'hC, 32'h0);
    chkRd(rd, 32'h7);
    $display("test unmapped done");
    final_report;
  end
endmodule
